// ### include/fci_consts.vh
// front-end chip interface constants
`ifndef FCI_CONSTS_VH
`define FCI_CONSTS_VH

`define FCI_ADDR_W 4
`define FCI_DATA_W 32

`define FCI_REG_CTRL 4'h0
`define FCI_REG_STATUS 4'h1
`define FCI_REG_PROG_A_TX 4'h2
`define FCI_REG_PROG_B_TX 4'h3
`define FCI_REG_PROG_CMD 4'h4
`define FCI_REG_PROG_A_RX 4'h5
`define FCI_REG_PROG_B_RX 4'h6
`define FCI_REG_CAPT_VALID 4'h7
`define FCI_REG_CAPT_DATA 4'h8

`define FCI_CTRL_PWR_LSB 0
`define FCI_CTRL_RST_LSB 2
`define FCI_CTRL_AOUT_LSB 4
`define FCI_CTRL_XCO_LSB 6
`define FCI_CTRL_RESET_VAL 10'h000

`define FCI_ST_ERR_LSB 0
`define FCI_ST_LATCH_LSB 4
`define FCI_ST_EVENT_LSB 8
`define FCI_ST_COINC_LSB 12
`define FCI_ST_READY_LSB 16
`define FCI_ST_BUSY_LSB 20

`define FCI_CMD_START_A 0
`define FCI_CMD_START_B 1
`define FCI_CMD_ODD_A 2
`define FCI_CMD_ODD_B 3

`define FCI_MSG_BITS 16
`define FCI_PROG_HALF 20
`define FCI_CRYS_HALF 2

`endif

// ### rtl/fci_sync.v
// three-stage synchroniser, a bit changes once stages two and three agree
`default_nettype none

module fci_sync #(
    parameter W = 1
) (
    input wire sys_clk,
    input wire rst,
    input wire [W-1:0] din,
    output reg [W-1:0] dout
);

reg [W-1:0] s1_reg;
reg [W-1:0] s2_reg;
reg [W-1:0] s3_reg;

always @(posedge sys_clk)
begin
    if (rst)
    begin
        s1_reg <= {W{1'b0}};
        s2_reg <= {W{1'b0}};
        s3_reg <= {W{1'b0}};
        dout <= {W{1'b0}};
    end
    else
    begin
        s1_reg <= din;
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        dout <= (s2_reg & ~(s2_reg ^ s3_reg)) | (dout & (s2_reg ^ s3_reg));
    end
end

endmodule

`default_nettype wire

// ### rtl/fci_top.v
// front-end chip pair control, programming link and conversion data capture
//
// Contract
// R01 - active-low reset pin synchronised before use
// R02 - all registers here clock on the rising system clock edge
// R03 - crystal clock edges drive a few registers and the divided clock output
// R04 - one power enable per pair, low from power-up until software sets it
// R05 - one active-low chip reset per pair, low holds both chips in reset
// R06 - one analogue output enable per pair, high enables both chips
// R07 - chip error inputs synchronised, low means that chip reports error
// R08 - analogue and digital latch-up input per pair, low means latch-up
// R09 - per pair bit clock changes on system edges; chips sample on its rise
// R10 - one shared serial data line per pair, changed on system clock edges
// R11 - per-chip active-high select frames each programming message
// R12 - readback sampled at bit clock rise only while that chip is selected; the engine samples it as the bit clock falls
// R13 - main event inputs are synchronised before use
// R14 - internal coincidence inputs are synchronised before use
// R15 - conversion ready is active high, means conversion complete
// R16 - external coincidence output per chip, changed on system clock edge
// R17 - parallel output enable held permanently low
// R18 - eight data bits sampled on system clock, bit 0 most significant
// R19 - async inputs synchronised; capture after synchronised ready
// R20 - divider and message length are parameters; clock idle when unselected
//
// Added by the designer: the register offsets and the address-and-strobe port.
`default_nettype none
`include "fci_consts.vh"

module fci_top #(
    parameter MSG_BITS = `FCI_MSG_BITS,
    parameter PROG_HALF = `FCI_PROG_HALF,
    parameter CRYS_HALF = `FCI_CRYS_HALF
) (
    input wire sys_clk,
    input wire rst,
    input wire ext_reset_low,
    input wire crystal_clock,
    output reg divided_clock_out,
    input wire [`FCI_ADDR_W-1:0] reg_addr,
    input wire [`FCI_DATA_W-1:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [`FCI_DATA_W-1:0] reg_rdata,
    output reg pair_a_power_enable,
    output reg pair_b_power_enable,
    output reg pair_a_chip_reset_low,
    output reg pair_b_chip_reset_low,
    output reg pair_a_analog_out_enable,
    output reg pair_b_analog_out_enable,
    input wire chip0_error_low,
    input wire chip1_error_low,
    input wire chip2_error_low,
    input wire chip3_error_low,
    input wire pair_a_analog_latchup_low,
    input wire pair_a_digital_latchup_low,
    input wire pair_b_analog_latchup_low,
    input wire pair_b_digital_latchup_low,
    output reg pair_a_prog_bit_clock,
    output reg pair_b_prog_bit_clock,
    output reg pair_a_prog_data_out,
    output reg pair_b_prog_data_out,
    output reg chip0_prog_select,
    output reg chip1_prog_select,
    output reg chip2_prog_select,
    output reg chip3_prog_select,
    input wire chip0_prog_readback,
    input wire chip1_prog_readback,
    input wire chip2_prog_readback,
    input wire chip3_prog_readback,
    input wire chip0_main_event,
    input wire chip1_main_event,
    input wire chip2_main_event,
    input wire chip3_main_event,
    input wire chip0_internal_coincidence,
    input wire chip1_internal_coincidence,
    input wire chip2_internal_coincidence,
    input wire chip3_internal_coincidence,
    input wire chip0_conversion_ready,
    input wire chip1_conversion_ready,
    input wire chip2_conversion_ready,
    input wire chip3_conversion_ready,
    output reg chip0_external_coincidence,
    output reg chip1_external_coincidence,
    output reg chip2_external_coincidence,
    output reg chip3_external_coincidence,
    output reg chip0_parallel_out_enable_low,
    output reg chip1_parallel_out_enable_low,
    output reg chip2_parallel_out_enable_low,
    output reg chip3_parallel_out_enable_low,
    input wire [0:7] chip0_conversion_data,
    input wire [0:7] chip1_conversion_data,
    input wire [0:7] chip2_conversion_data,
    input wire [0:7] chip3_conversion_data
);

localparam ST_IDLE = 2'b00;
localparam ST_LOW = 2'b01;
localparam ST_HIGH = 2'b10;
localparam ST_END = 2'b11;

wire rst_ext_sync;
wire rst_int;
wire [24:0] async_in;
wire [24:0] sync_out;
wire [3:0] err_s;
wire [3:0] latch_s;
wire [3:0] event_s;
wire [3:0] coinc_s;
wire [3:0] ready_s;
wire [3:0] rb_s;
wire crys_s;

reg [9:0] ctrl_reg;
reg [MSG_BITS-1:0] tx_reg [0:1];
reg [MSG_BITS-1:0] rx_reg [0:1];
reg [MSG_BITS-1:0] shift_reg [0:1];
reg [1:0] state_reg [0:1];
reg [15:0] div_reg [0:1];
reg [15:0] bit_reg [0:1];
reg [1:0] odd_reg;
reg [1:0] sclk_reg;
reg [1:0] sdata_reg;
reg [1:0] sel_even_reg;
reg [1:0] sel_odd_reg;
reg [3:0] ready_prev_reg;
reg [3:0] valid_reg;
reg [7:0] capt_reg [0:3];
reg crys_prev_reg;
reg [15:0] crys_cnt_reg;
reg [`FCI_DATA_W-1:0] rdata_next;
integer p;

function [15:0] half_count;
    input integer n;
    begin
        half_count = n[15:0] - 16'h0001;
    end
endfunction

// R01 reset synchroniser
fci_sync #(
    .W(1)
) u_rst_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .din(ext_reset_low),
    .dout(rst_ext_sync)
);

assign rst_int = rst | ~rst_ext_sync;

// R07 R08 inverted to active high before synchronising
assign async_in = {crystal_clock,
    chip3_prog_readback, chip2_prog_readback, chip1_prog_readback, chip0_prog_readback,
    chip3_conversion_ready, chip2_conversion_ready, chip1_conversion_ready, chip0_conversion_ready,
    chip3_internal_coincidence, chip2_internal_coincidence,
    chip1_internal_coincidence, chip0_internal_coincidence,
    chip3_main_event, chip2_main_event, chip1_main_event, chip0_main_event,
    ~pair_b_digital_latchup_low, ~pair_b_analog_latchup_low,
    ~pair_a_digital_latchup_low, ~pair_a_analog_latchup_low,
    ~chip3_error_low, ~chip2_error_low, ~chip1_error_low, ~chip0_error_low};

// R19 every chip input except conversion data, and the crystal clock, synchronised
fci_sync #(
    .W(25)
) u_in_sync (
    .sys_clk(sys_clk),
    .rst(rst_int),
    .din(async_in),
    .dout(sync_out)
);

// R07 error flags per chip
assign err_s = sync_out[3:0];
// R08 latch-up flags per pair
assign latch_s = sync_out[7:4];
// R13 main event indications
assign event_s = sync_out[11:8];
// R14 internal coincidence indications
assign coinc_s = sync_out[15:12];
// R15 conversion ready active high
assign ready_s = sync_out[19:16];
assign rb_s = sync_out[23:20];
assign crys_s = sync_out[24];

// R03 crystal-edge registers and divided clock
always @(posedge sys_clk)
begin
    if (rst_int)
    begin
        crys_prev_reg <= 1'b0;
        crys_cnt_reg <= 16'h0000;
        divided_clock_out <= 1'b0;
    end
    else
    begin
        crys_prev_reg <= crys_s;
        if (crys_s && !crys_prev_reg)
        begin
            if (crys_cnt_reg == half_count(CRYS_HALF))
            begin
                crys_cnt_reg <= 16'h0000;
                divided_clock_out <= ~divided_clock_out;
            end
            else
            begin
                crys_cnt_reg <= crys_cnt_reg + 16'h0001;
            end
        end
    end
end

// R02 control register and pin outputs on rising edge
always @(posedge sys_clk)
begin
    if (rst_int)
    begin
        ctrl_reg <= `FCI_CTRL_RESET_VAL;
        tx_reg[0] <= {MSG_BITS{1'b0}};
        tx_reg[1] <= {MSG_BITS{1'b0}};
    end
    else if (reg_wr)
    begin
        case (reg_addr)
            `FCI_REG_CTRL: ctrl_reg <= reg_wdata[9:0];
            `FCI_REG_PROG_A_TX: tx_reg[0] <= reg_wdata[MSG_BITS-1:0];
            `FCI_REG_PROG_B_TX: tx_reg[1] <= reg_wdata[MSG_BITS-1:0];
            default: ctrl_reg <= ctrl_reg;
        endcase
    end
end

always @(posedge sys_clk)
begin
    if (rst_int)
    begin
        // R04 power off during power-up
        pair_a_power_enable <= 1'b0;
        pair_b_power_enable <= 1'b0;
        // R05 chips held in reset
        pair_a_chip_reset_low <= 1'b0;
        pair_b_chip_reset_low <= 1'b0;
        pair_a_analog_out_enable <= 1'b0;
        pair_b_analog_out_enable <= 1'b0;
        chip0_external_coincidence <= 1'b0;
        chip1_external_coincidence <= 1'b0;
        chip2_external_coincidence <= 1'b0;
        chip3_external_coincidence <= 1'b0;
    end
    else
    begin
        // R04 power enables
        pair_a_power_enable <= ctrl_reg[`FCI_CTRL_PWR_LSB];
        pair_b_power_enable <= ctrl_reg[`FCI_CTRL_PWR_LSB+1];
        // R05 control bit set holds pair in reset
        pair_a_chip_reset_low <= ~ctrl_reg[`FCI_CTRL_RST_LSB];
        pair_b_chip_reset_low <= ~ctrl_reg[`FCI_CTRL_RST_LSB+1];
        // R06 analogue output enables
        pair_a_analog_out_enable <= ctrl_reg[`FCI_CTRL_AOUT_LSB];
        pair_b_analog_out_enable <= ctrl_reg[`FCI_CTRL_AOUT_LSB+1];
        // R16 external coincidence per chip
        chip0_external_coincidence <= ctrl_reg[`FCI_CTRL_XCO_LSB];
        chip1_external_coincidence <= ctrl_reg[`FCI_CTRL_XCO_LSB+1];
        chip2_external_coincidence <= ctrl_reg[`FCI_CTRL_XCO_LSB+2];
        chip3_external_coincidence <= ctrl_reg[`FCI_CTRL_XCO_LSB+3];
    end
end

// R17 parallel output enable always asserted
always @(posedge sys_clk)
begin
    chip0_parallel_out_enable_low <= 1'b0;
    chip1_parallel_out_enable_low <= 1'b0;
    chip2_parallel_out_enable_low <= 1'b0;
    chip3_parallel_out_enable_low <= 1'b0;
end

// programming engines, one per pair
always @(posedge sys_clk)
begin
    if (rst_int)
    begin
        for (p = 0; p < 2; p = p + 1)
        begin
            state_reg[p] <= ST_IDLE;
            div_reg[p] <= 16'h0000;
            bit_reg[p] <= 16'h0000;
            shift_reg[p] <= {MSG_BITS{1'b0}};
            rx_reg[p] <= {MSG_BITS{1'b0}};
        end
        odd_reg <= 2'b00;
        sclk_reg <= 2'b00;
        sdata_reg <= 2'b00;
        sel_even_reg <= 2'b00;
        sel_odd_reg <= 2'b00;
    end
    else
    begin
        for (p = 0; p < 2; p = p + 1)
        begin
            case (state_reg[p])
                ST_IDLE:
                begin
                    // R20 clock held low while idle
                    sclk_reg[p] <= 1'b0;
                    if (reg_wr && reg_addr == `FCI_REG_PROG_CMD && reg_wdata[p])
                    begin
                        // R11 select frames the message
                        odd_reg[p] <= reg_wdata[`FCI_CMD_ODD_A+p];
                        sel_even_reg[p] <= ~reg_wdata[`FCI_CMD_ODD_A+p];
                        sel_odd_reg[p] <= reg_wdata[`FCI_CMD_ODD_A+p];
                        shift_reg[p] <= tx_reg[p];
                        // R10 first bit, msb first
                        sdata_reg[p] <= tx_reg[p][MSG_BITS-1];
                        div_reg[p] <= 16'h0000;
                        bit_reg[p] <= 16'h0000;
                        state_reg[p] <= ST_LOW;
                    end
                end
                ST_LOW:
                begin
                    if (div_reg[p] == half_count(PROG_HALF))
                    begin
                        // R09 rising bit clock, data already stable
                        sclk_reg[p] <= 1'b1;
                        div_reg[p] <= 16'h0000;
                        state_reg[p] <= ST_HIGH;
                    end
                    else
                    begin
                        div_reg[p] <= div_reg[p] + 16'h0001;
                    end
                end
                ST_HIGH:
                begin
                    if (div_reg[p] == half_count(PROG_HALF))
                    begin
                        // R12 readback of the selected chip only
                        rx_reg[p] <= {rx_reg[p][MSG_BITS-2:0], rb_s[2*p + odd_reg[p]]};
                        sclk_reg[p] <= 1'b0;
                        div_reg[p] <= 16'h0000;
                        bit_reg[p] <= bit_reg[p] + 16'h0001;
                        if (bit_reg[p] == half_count(MSG_BITS))
                        begin
                            state_reg[p] <= ST_END;
                        end
                        else
                        begin
                            // R10 next bit while clock low
                            shift_reg[p] <= {shift_reg[p][MSG_BITS-2:0], 1'b0};
                            sdata_reg[p] <= shift_reg[p][MSG_BITS-2];
                            state_reg[p] <= ST_LOW;
                        end
                    end
                    else
                    begin
                        div_reg[p] <= div_reg[p] + 16'h0001;
                    end
                end
                ST_END:
                begin
                    if (div_reg[p] == half_count(PROG_HALF))
                    begin
                        // R11 select released after last bit
                        sel_even_reg[p] <= 1'b0;
                        sel_odd_reg[p] <= 1'b0;
                        sdata_reg[p] <= 1'b0;
                        state_reg[p] <= ST_IDLE;
                    end
                    else
                    begin
                        div_reg[p] <= div_reg[p] + 16'h0001;
                    end
                end
                default:
                begin
                    state_reg[p] <= ST_IDLE;
                end
            endcase
        end
    end
end

// R09 R10 R11 pin copies of the engine state
always @*
begin
    pair_a_prog_bit_clock = sclk_reg[0];
    pair_b_prog_bit_clock = sclk_reg[1];
    pair_a_prog_data_out = sdata_reg[0];
    pair_b_prog_data_out = sdata_reg[1];
    chip0_prog_select = sel_even_reg[0];
    chip1_prog_select = sel_odd_reg[0];
    chip2_prog_select = sel_even_reg[1];
    chip3_prog_select = sel_odd_reg[1];
end

// R18 R19 capture after synchronised ready rises
always @(posedge sys_clk)
begin
    if (rst_int)
    begin
        ready_prev_reg <= 4'h0;
        valid_reg <= 4'h0;
        for (p = 0; p < 4; p = p + 1)
        begin
            capt_reg[p] <= 8'h00;
        end
    end
    else
    begin
        ready_prev_reg <= ready_s;
        for (p = 0; p < 4; p = p + 1)
        begin
            if (ready_s[p] && !ready_prev_reg[p])
            begin
                valid_reg[p] <= 1'b1;
            end
            else if (reg_wr && reg_addr == `FCI_REG_CAPT_VALID && reg_wdata[p])
            begin
                valid_reg[p] <= 1'b0;
            end
        end
        if (ready_s[0] && !ready_prev_reg[0])
        begin
            capt_reg[0] <= chip0_conversion_data;
        end
        if (ready_s[1] && !ready_prev_reg[1])
        begin
            capt_reg[1] <= chip1_conversion_data;
        end
        if (ready_s[2] && !ready_prev_reg[2])
        begin
            capt_reg[2] <= chip2_conversion_data;
        end
        if (ready_s[3] && !ready_prev_reg[3])
        begin
            capt_reg[3] <= chip3_conversion_data;
        end
    end
end

// register read mux
always @*
begin
    rdata_next = {`FCI_DATA_W{1'b0}};
    case (reg_addr)
        `FCI_REG_CTRL: rdata_next[9:0] = ctrl_reg;
        `FCI_REG_STATUS: rdata_next[21:0] = {(state_reg[1] != ST_IDLE), (state_reg[0] != ST_IDLE),
            ready_s, coinc_s, event_s, latch_s, err_s};
        `FCI_REG_PROG_A_TX: rdata_next[MSG_BITS-1:0] = tx_reg[0];
        `FCI_REG_PROG_B_TX: rdata_next[MSG_BITS-1:0] = tx_reg[1];
        `FCI_REG_PROG_A_RX: rdata_next[MSG_BITS-1:0] = rx_reg[0];
        `FCI_REG_PROG_B_RX: rdata_next[MSG_BITS-1:0] = rx_reg[1];
        `FCI_REG_CAPT_VALID: rdata_next[3:0] = valid_reg;
        `FCI_REG_CAPT_DATA: rdata_next = {capt_reg[3], capt_reg[2], capt_reg[1], capt_reg[0]};
        default: rdata_next = {`FCI_DATA_W{1'b0}};
    endcase
end

always @(posedge sys_clk)
begin
    if (rst_int)
    begin
        reg_rdata <= {`FCI_DATA_W{1'b0}};
    end
    else if (reg_rd)
    begin
        reg_rdata <= rdata_next;
    end
    else
    begin
        reg_rdata <= {`FCI_DATA_W{1'b0}};
    end
end

endmodule

`default_nettype wire

// ### sim/fci_asserts.sv
// port assertions
`default_nettype none
module fci_asserts #(
    parameter int PROG_HALF = 20
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic pair_a_power_enable,
    input wire logic pair_a_chip_reset_low,
    input wire logic chip0_parallel_out_enable_low,
    input wire logic pair_a_prog_bit_clock,
    input wire logic pair_a_prog_data_out,
    input wire logic chip0_prog_select,
    input wire logic chip1_prog_select
);
    timeunit 1ns;
    timeprecision 100ps;
    wire logic asel = chip0_prog_select | chip1_prog_select;
    logic [7:0] hi_cnt_reg;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // length of the present high phase
    always_ff @(posedge sys_clk)
    begin
        if (rst || !pair_a_prog_bit_clock)
            hi_cnt_reg <= 8'h00;
        else
            hi_cnt_reg <= hi_cnt_reg + 8'h01;
    end
    a_rd_idle: // idle read data
    assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside read cycle");
    a_pwr_follow: // power follows
    assert property (reg_wr && reg_addr == 4'h0 |-> ##2 pair_a_power_enable == $past(reg_wdata[0], 2))
        else $error("power enable wrong");
    a_rst_follow: // reset follows
    assert property (reg_wr && reg_addr == 4'h0 |-> ##2 pair_a_chip_reset_low == !$past(reg_wdata[2], 2))
        else $error("chip reset wrong");
    a_pen_low: // enable held
    assert property (!chip0_parallel_out_enable_low)
        else $error("parallel enable released");
    a_clk_idle: // idle clock
    assert property (!asel |-> !pair_a_prog_bit_clock)
        else $error("bit clock runs unselected");
    a_clk_high: // high phase
    assert property ($fell(pair_a_prog_bit_clock) |-> hi_cnt_reg == 8'(PROG_HALF))
        else $error("bit clock high phase length");
    a_data_edge: // data at fall
    assert property (asel && $past(asel) && $changed(pair_a_prog_data_out) |-> $fell(pair_a_prog_bit_clock))
        else $error("data moved off falling clock");
    a_sel_one: // single select
    assert property (!(chip0_prog_select && chip1_prog_select))
        else $error("two selects at once");
    cover property ($rose(pair_a_power_enable));
    cover property ($fell(asel));
    cover property (reg_rd ##1 reg_rdata != 32'h0);
endmodule
bind fci_top fci_asserts #(.PROG_HALF(PROG_HALF)) u_chk (.*);
`default_nettype wire

// ### sim/fci_pair_model.sv
// behavioural pair of front-end chips on one programming link
`default_nettype none
module fci_pair_model #(
    parameter int N = 16
) (
    input wire logic bclk,
    input wire logic sdo,
    input wire logic rst_low,
    input wire logic sel0,
    input wire logic sel1,
    output logic rb0,
    output logic rb1
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [N-1:0] held0, held1;
    logic in0, in1;
    always @(posedge bclk)
    begin
        if (sel0)
            in0 <= sdo;
        if (sel1)
            in1 <= sdo;
    end
    always @(negedge bclk or negedge rst_low)
    begin
        if (!rst_low)
        begin
            held0 <= '0;
            held1 <= '0;
        end
        else
        begin
            if (sel0)
                held0 <= {held0[N-2:0], in0};
            if (sel1)
                held1 <= {held1[N-2:0], in1};
        end
    end
    // unselected line shows the inverted held bit
    assign rb0 = sel0 ? held0[N-1] : ~held0[N-1];
    assign rb1 = sel1 ? held1[N-1] : ~held1[N-1];
endmodule
`default_nettype wire

// ### sim/testbench.sv
// self-checking bench
`default_nettype none
`include "fci_consts.vh"
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 0, rst = 1, ext_reset_low = 1, crystal_clock = 0, reg_wr = 0, reg_rd = 0, div_q = 0;
    logic [3:0] reg_addr = 4'h0, err_low = 4'hF, lu_low = 4'hF, ev = 4'h0, co = 4'h0, rdy = 4'h0;
    logic [31:0] reg_wdata = 32'h0, rd_v, cap = 32'h0;
    logic [0:7] cd [4] = '{default: 8'h00};
    wire logic [31:0] reg_rdata;
    wire logic pwr_a, pwr_b, crl_a, crl_b, ao_a, ao_b, bck_a, bck_b, sd_a, sd_b, div_clk;
    wire logic [3:0] sel, rb, xco, pen_low;
    int err_total = 0, n_compared = 0, div_cnt = 0;
    int hm [4] = '{default: 0};
    fci_top #(.MSG_BITS(16), .PROG_HALF(4), .CRYS_HALF(2)) dut (
        .sys_clk(sys_clk), .rst(rst), .ext_reset_low(ext_reset_low), .crystal_clock(crystal_clock),
        .divided_clock_out(div_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pair_a_power_enable(pwr_a), .pair_b_power_enable(pwr_b),
        .pair_a_chip_reset_low(crl_a), .pair_b_chip_reset_low(crl_b), .pair_a_analog_out_enable(ao_a),
        .pair_b_analog_out_enable(ao_b), .chip0_error_low(err_low[0]), .chip1_error_low(err_low[1]),
        .chip2_error_low(err_low[2]), .chip3_error_low(err_low[3]), .pair_a_analog_latchup_low(lu_low[0]),
        .pair_a_digital_latchup_low(lu_low[1]), .pair_b_analog_latchup_low(lu_low[2]),
        .pair_b_digital_latchup_low(lu_low[3]), .pair_a_prog_bit_clock(bck_a), .pair_b_prog_bit_clock(bck_b),
        .pair_a_prog_data_out(sd_a), .pair_b_prog_data_out(sd_b), .chip0_prog_select(sel[0]),
        .chip1_prog_select(sel[1]), .chip2_prog_select(sel[2]), .chip3_prog_select(sel[3]),
        .chip0_prog_readback(rb[0]), .chip1_prog_readback(rb[1]), .chip2_prog_readback(rb[2]),
        .chip3_prog_readback(rb[3]), .chip0_main_event(ev[0]), .chip1_main_event(ev[1]),
        .chip2_main_event(ev[2]), .chip3_main_event(ev[3]), .chip0_internal_coincidence(co[0]),
        .chip1_internal_coincidence(co[1]), .chip2_internal_coincidence(co[2]),
        .chip3_internal_coincidence(co[3]), .chip0_conversion_ready(rdy[0]), .chip1_conversion_ready(rdy[1]),
        .chip2_conversion_ready(rdy[2]), .chip3_conversion_ready(rdy[3]), .chip0_external_coincidence(xco[0]),
        .chip1_external_coincidence(xco[1]), .chip2_external_coincidence(xco[2]),
        .chip3_external_coincidence(xco[3]), .chip0_parallel_out_enable_low(pen_low[0]),
        .chip1_parallel_out_enable_low(pen_low[1]), .chip2_parallel_out_enable_low(pen_low[2]),
        .chip3_parallel_out_enable_low(pen_low[3]), .chip0_conversion_data(cd[0]),
        .chip1_conversion_data(cd[1]), .chip2_conversion_data(cd[2]), .chip3_conversion_data(cd[3])
    );
    fci_pair_model u_pa (.bclk(bck_a), .sdo(sd_a), .rst_low(crl_a), .sel0(sel[0]), .sel1(sel[1]),
        .rb0(rb[0]), .rb1(rb[1]));
    fci_pair_model u_pb (.bclk(bck_b), .sdo(sd_b), .rst_low(crl_b), .sel0(sel[2]), .sel1(sel[3]),
        .rb0(rb[2]), .rb1(rb[3]));
    initial forever #12.5 sys_clk = ~sys_clk;
    initial forever #55 crystal_clock = ~crystal_clock;
    always @(posedge sys_clk)
    begin
        div_q <= div_clk;
        if (div_clk !== div_q)
            div_cnt++;
    end
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        rd_v = reg_rdata;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        n_compared++;
        if (g !== e)
        begin
            err_total++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask
    task automatic results();
        $display("compared %0d errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        logic [31:0] d, c;
        int i, n, k;
        void'($urandom(32'h2C74));
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        chk(pwr_a | pwr_b | crl_a | crl_b, 0, "outputs in reset");
        rd(`FCI_REG_CTRL);
        chk(rd_v, 0, "ctrl reset");
        rd(4'hF);
        chk(rd_v, 0, "unmapped read");
        for (i = 0; i < 6; i++)
        begin
            d = $urandom & 32'h3FF;
            wr(`FCI_REG_CTRL, d);
            rd(`FCI_REG_CTRL);
            chk(rd_v, d, "ctrl readback");
            chk({xco, ao_b, ao_a, ~crl_b, ~crl_a, pwr_b, pwr_a}, d, "pair outputs");
            chk(pen_low, 0, "parallel enable");
        end
        for (i = 0; i < 4; i++)
        begin
            d = $urandom & 32'hFFFF;
            @(posedge sys_clk);
            err_low <= ~d[3:0];
            lu_low <= ~d[7:4];
            ev <= d[11:8];
            co <= d[15:12];
            repeat (6) @(posedge sys_clk);
            rd(`FCI_REG_STATUS);
            chk(rd_v, d, "status inputs");
        end
        for (n = 0; n < 4; n++)
        begin
            d = $urandom & 32'hFF;
            @(posedge sys_clk);
            for (k = 0; k < 8; k++)
                cd[n][k] <= d[7 - k];
            cap[8 * n +: 8] = d[7:0];
            repeat (2) @(posedge sys_clk);
            rdy[n] <= 1'b1;
            repeat (6) @(posedge sys_clk);
            cd[n] <= ~cd[n];
            rd(`FCI_REG_CAPT_VALID);
            chk(rd_v, (2 << n) - 1, "capture valid");
            rd(`FCI_REG_CAPT_DATA);
            chk(rd_v, cap, "capture data");
        end
        @(posedge sys_clk);
        rdy <= 4'h0;
        wr(`FCI_REG_CAPT_VALID, 32'hF);
        rd(`FCI_REG_CAPT_VALID);
        chk(rd_v, 0, "valid clear");
        wr(`FCI_REG_CTRL, 32'h003);
        for (i = 0; i < 4; i++)
        begin
            n = i % 2;
            d = $urandom & 32'hFFFF;
            c = $urandom & 32'hFFFF;
            wr(`FCI_REG_PROG_A_TX, d);
            wr(`FCI_REG_PROG_B_TX, c);
            wr(`FCI_REG_PROG_CMD, 3 | (n * 12));
            wr(`FCI_REG_PROG_CMD, 3 | ((1 - n) * 12));
            k = 0;
            do
            begin
                rd(`FCI_REG_STATUS);
                k++;
            end
            while (rd_v[21:20] !== 2'b00 && k < 200);
            if (k >= 200)
            begin
                err_total++;
                $display("ERROR %0t link stays busy", $time);
                results();
            end
            rd(`FCI_REG_PROG_A_RX);
            chk(rd_v, hm[n], "readback a");
            rd(`FCI_REG_PROG_B_RX);
            chk(rd_v, hm[2 + n], "readback b");
            hm[n] = d;
            hm[2 + n] = c;
        end
        wr(`FCI_REG_CTRL, 32'h3FF);
        @(posedge sys_clk);
        ext_reset_low <= 1'b0;
        repeat (8) @(posedge sys_clk);
        chk(pwr_a | pwr_b, 0, "power in pin reset");
        ext_reset_low <= 1'b1;
        repeat (8) @(posedge sys_clk);
        rd(`FCI_REG_CTRL);
        chk(rd_v, 0, "ctrl after pin reset");
        k = div_cnt;
        repeat (176) @(posedge sys_clk);
        chk((div_cnt - k) inside {[19:21]}, 1, "divided clock rate");
        results();
    end
endmodule
`default_nettype wire
